// *** logic/eisr_pkg.sv ***
// Purpose: constants for the emergency stop / inspection run sequencer
// Assumes: frequencies in 0.01 Hz units, times in 0.01 s units
// Notes:   registers sit on an AHB-Lite slave, one aligned word each
package eisr_pkg;
	localparam logic [7:0]  ADDR_FUNC     = 8'h00;
	localparam logic [7:0]  ADDR_PRIO     = 8'h04;
	localparam logic [7:0]  ADDR_ESTOP_T  = 8'h08;
	localparam logic [7:0]  ADDR_INSP_SPD = 8'h0c;
	localparam logic [7:0]  ADDR_INSP_T   = 8'h10;
	localparam logic [7:0]  ADDR_UPPER    = 8'h14;
	localparam logic [7:0]  ADDR_LOWER    = 8'h18;
	localparam logic [7:0]  ADDR_MINF     = 8'h1c;
	localparam logic [7:0]  ADDR_STATUS   = 8'h20;
	localparam logic [7:0]  ADDR_FREQ     = 8'h24;
	localparam logic [7:0]  ADDR_ACCEL_T  = 8'h28;
	localparam logic [7:0]  FUNC_ESTOP_NO = 8'h0f;
	localparam logic [7:0]  FUNC_ESTOP_NC = 8'h11;
	localparam logic [7:0]  FUNC_INSP     = 8'h54;
	localparam logic [15:0] RST_ESTOP_T   = 16'h0096;
	localparam logic [15:0] RST_INSP_SPD  = 16'h09c4;
	localparam logic [15:0] RST_INSP_T    = 16'h0000;
	localparam logic [15:0] RST_UPPER     = 16'h0000;
	localparam logic [15:0] RST_LOWER     = 16'h0000;
	localparam logic [15:0] RST_MINF      = 16'h0032;
	localparam logic [15:0] RST_ACCEL_T   = 16'h0096;
	localparam logic [1:0]  RST_PRIO      = 2'h0;
	localparam logic [15:0] CARRIER_INSP  = 16'h07d0;
	localparam logic [15:0] CARRIER_NORM  = 16'h1f40;
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          TICK_HZ       = 100;
	localparam int          TICK_CYC      = CLK_HZ / TICK_HZ;
	localparam int          ST_RUN        = 0;
	localparam int          ST_INSP       = 1;
	localparam int          ST_ESTOP      = 2;
	localparam int          ST_BRAKE      = 3;
	localparam int          ST_CONT       = 4;
	localparam int          ST_BB         = 5;
	typedef enum logic [2:0] {S_IDLE, S_ACCEL, S_RUN, S_DECEL, S_BB} eisr_state_t;
endpackage : eisr_pkg

// *** logic/eisr_sequencer.sv ***
// Purpose: emergency stop and inspection run sequencing of a lift drive
// Assumes: direction and select inputs are asynchronous contacts
// Notes:   ramp advances once per tick; rate = full step over set time
`timescale 1ns/100ps
module eisr_sequencer
	import eisr_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// controller inputs
	input  wire logic [4:0]  mf_in,
	input  wire logic        run_up,
	input  wire logic        run_down,
	input  wire logic [15:0] sel_speed,
	// drive outputs
	output logic [15:0]      out_freq,
	output logic             baseblock,
	output logic             brake_open,
	output logic             contactor,
	output logic [15:0]      carrier_hz,
	output logic             estop_active
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [6:0] s1_r, s2_r, s3_r, flt_r;
	logic [6:0] flt_nxt;
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r  <= 7'h00;
			s2_r  <= 7'h00;
			s3_r  <= 7'h00;
			flt_r <= 7'h00;
		end else begin
			s1_r  <= {run_down, run_up, mf_in};
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			flt_r <= flt_nxt;
		end
	end
	wire logic [4:0] mf  = flt_r[4:0];
	wire logic       dir = flt_r[5] | flt_r[6];

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [39:0] func_r, func_nxt;
	logic [1:0]  prio_r, prio_nxt;
	logic [15:0] estop_t_r, estop_t_nxt, insp_spd_r, insp_spd_nxt;
	logic [15:0] insp_t_r, insp_t_nxt, upper_r, upper_nxt;
	logic [15:0] lower_r, lower_nxt, minf_r, minf_nxt, accel_t_r, accel_t_nxt;
	logic        wr_pend_r, wr_pend_nxt;
	logic [7:0]  wr_addr_r, wr_addr_nxt;
	logic [31:0] hrdata_nxt;
	logic        idle, insp_on, run_on;
	wire logic   addr_ok = (htrans[1] && hsel && hready);

	always_comb begin
		func_nxt     = func_r;
		prio_nxt     = prio_r;
		estop_t_nxt  = estop_t_r;
		insp_spd_nxt = insp_spd_r;
		insp_t_nxt   = insp_t_r;
		upper_nxt    = upper_r;
		lower_nxt    = lower_r;
		minf_nxt     = minf_r;
		accel_t_nxt  = accel_t_r;
		wr_pend_nxt  = addr_ok && hwrite;
		wr_addr_nxt  = addr_ok ? haddr : wr_addr_r;
		hrdata_nxt   = hrdata;
		if (wr_pend_r && idle) begin
			case (wr_addr_r)
				ADDR_FUNC:     func_nxt     = {hwdata[7:0], func_r[31:0]};
				ADDR_PRIO:     prio_nxt     = hwdata[1:0];
				ADDR_ESTOP_T:  estop_t_nxt  = hwdata[15:0];
				ADDR_INSP_SPD: insp_spd_nxt = hwdata[15:0];
				ADDR_INSP_T:   insp_t_nxt   = hwdata[15:0];
				ADDR_UPPER:    upper_nxt    = hwdata[15:0];
				ADDR_LOWER:    lower_nxt    = hwdata[15:0];
				ADDR_MINF:     minf_nxt     = hwdata[15:0];
				ADDR_ACCEL_T:  accel_t_nxt  = hwdata[15:0];
				default:       func_nxt     = func_r;
			endcase
			// function word write loads terminals 4 down to 1 from bytes 0 to 3, terminal 0 keeps its code
			if (wr_addr_r == ADDR_FUNC)
				func_nxt = {hwdata[7:0], hwdata[15:8], hwdata[23:16], hwdata[31:24],
					func_r[7:0]};
		end
		if (addr_ok && !hwrite) begin
			case (haddr)
				ADDR_FUNC:     hrdata_nxt = func_r[39:8];
				ADDR_PRIO:     hrdata_nxt = {30'h0, prio_r};
				ADDR_ESTOP_T:  hrdata_nxt = {16'h0, estop_t_r};
				ADDR_INSP_SPD: hrdata_nxt = {16'h0, insp_spd_r};
				ADDR_INSP_T:   hrdata_nxt = {16'h0, insp_t_r};
				ADDR_UPPER:    hrdata_nxt = {16'h0, upper_r};
				ADDR_LOWER:    hrdata_nxt = {16'h0, lower_r};
				ADDR_MINF:     hrdata_nxt = {16'h0, minf_r};
				ADDR_ACCEL_T:  hrdata_nxt = {16'h0, accel_t_r};
				ADDR_STATUS:   hrdata_nxt = {26'h0, baseblock, contactor, brake_open,
					estop_active, insp_on, run_on};
				ADDR_FREQ:     hrdata_nxt = {16'h0, out_freq};
				default:       hrdata_nxt = 32'h0;
			endcase
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			func_r     <= 40'h0;
			prio_r     <= RST_PRIO;
			estop_t_r  <= RST_ESTOP_T;
			insp_spd_r <= RST_INSP_SPD;
			insp_t_r   <= RST_INSP_T;
			upper_r    <= RST_UPPER;
			lower_r    <= RST_LOWER;
			minf_r     <= RST_MINF;
			accel_t_r  <= RST_ACCEL_T;
			wr_pend_r  <= 1'b0;
			wr_addr_r  <= 8'h00;
			hrdata     <= 32'h0;
		end else begin
			func_r     <= func_nxt;
			prio_r     <= prio_nxt;
			estop_t_r  <= estop_t_nxt;
			insp_spd_r <= insp_spd_nxt;
			insp_t_r   <= insp_t_nxt;
			upper_r    <= upper_nxt;
			lower_r    <= lower_nxt;
			minf_r     <= minf_nxt;
			accel_t_r  <= accel_t_nxt;
			wr_pend_r  <= wr_pend_nxt;
			wr_addr_r  <= wr_addr_nxt;
			hrdata     <= hrdata_nxt;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------------------------------
	// input functions
	// ----------------------------------------------------------------
	function automatic logic has_code(input logic [39:0] f, input logic [7:0] c);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (f[i*8 +: 8] == c)
				r = 1'b1;
		end
		return r;
	endfunction : has_code

	logic estop_cmd, insp_dig_cmd, insp_cmp_cmd, insp_cmd;
	always_comb begin
		estop_cmd    = 1'b0;
		insp_dig_cmd = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (func_r[i*8 +: 8] == FUNC_ESTOP_NO && mf[i])
				estop_cmd = 1'b1;
			if (func_r[i*8 +: 8] == FUNC_ESTOP_NC && !mf[i])
				estop_cmd = 1'b1;
			if (func_r[i*8 +: 8] == FUNC_INSP && mf[i] && (prio_r == 2'h1 || prio_r == 2'h2))
				insp_dig_cmd = 1'b1;
		end
		// comparison mode gating, window lower < v <= upper
		insp_cmp_cmd = (prio_r == 2'h0 || prio_r == 2'h3) && !has_code(func_r, FUNC_INSP)
			&& (sel_speed > lower_r) && (sel_speed <= upper_r);
		insp_cmd = insp_dig_cmd | insp_cmp_cmd;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	eisr_state_t st_r, st_nxt;
	logic [31:0] tick_r, tick_nxt;
	logic [15:0] freq_nxt, target;
	logic        estop_nxt, insp_nxt, insp_run_r, brake_nxt, cont_nxt, bb_nxt;
	logic        dir_d_r, insp_d_r;
	logic [15:0] step;
	wire logic   tick = (tick_r == TICK_CYCLES - 1);
	wire logic   stop_edge = (dir_d_r && !dir) || (insp_d_r && !insp_cmd && insp_run_r);

	function automatic logic [15:0] ramp_step(input logic [15:0] t);
		return (t == 16'h0) ? 16'hffff : ((RST_INSP_SPD / t) + 16'h1);
	endfunction : ramp_step

	assign idle   = (st_r == S_IDLE);
	assign run_on = !idle;
	assign target = insp_run_r ? insp_spd_r : sel_speed;
	assign carrier_hz = insp_run_r ? CARRIER_INSP : CARRIER_NORM;
	assign insp_on = insp_run_r;

	always_comb begin
		st_nxt    = st_r;
		tick_nxt  = tick ? 32'h0 : tick_r + 32'h1;
		freq_nxt  = out_freq;
		estop_nxt = estop_active;
		insp_nxt  = insp_run_r;
		brake_nxt = brake_open;
		cont_nxt  = contactor;
		bb_nxt    = baseblock;
		step      = ramp_step(accel_t_r);
		if (estop_cmd && !idle)
			estop_nxt = 1'b1;
		// clear once run and stop both off and output at zero
		if (estop_active && !estop_cmd && !dir && out_freq == 16'h0)
			estop_nxt = 1'b0;
		case (st_r)
			S_IDLE: begin
				bb_nxt = 1'b1;
				// no restart while latched
				// start on a fresh direction edge only, a held one never restarts
				if (dir && !dir_d_r && !estop_active && !estop_cmd) begin
					st_nxt    = S_ACCEL;
					insp_nxt  = insp_cmd;
					cont_nxt  = 1'b1;
					bb_nxt    = 1'b0;
					brake_nxt = 1'b1;
				end
			end
			S_ACCEL, S_RUN: begin
				if (tick)
					freq_nxt = (out_freq + step >= target || out_freq + step < out_freq)
						? target : out_freq + step;
				if (estop_cmd || estop_active) begin
					st_nxt = S_DECEL;
				end else if (stop_edge || !dir) begin
					if (insp_run_r && insp_t_r == 16'h0) begin
						st_nxt    = S_BB;
						bb_nxt    = 1'b1;
						brake_nxt = 1'b0;
						cont_nxt  = 1'b0;
						freq_nxt  = 16'h0;
					end else begin
						st_nxt = S_DECEL;
					end
				end else if (freq_nxt == target) begin
					st_nxt = S_RUN;
				end
			end
			S_DECEL: begin
				// emergency decel time used on emergency stop, else inspection or accel time
				step = ramp_step(estop_active || estop_cmd ? estop_t_r :
					(insp_run_r ? insp_t_r : accel_t_r));
				if (tick)
					freq_nxt = (out_freq > step) ? out_freq - step : 16'h0;
				// brake and contactor drop at minimum
				if (freq_nxt <= minf_r) begin
					brake_nxt = 1'b0;
					cont_nxt  = 1'b0;
					freq_nxt  = 16'h0;
					st_nxt    = S_BB;
				end
			end
			S_BB: begin
				if (!brake_open) begin
					bb_nxt   = 1'b1;
					insp_nxt = 1'b0;
					st_nxt   = S_IDLE;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		if (estop_cmd && !idle)
			estop_nxt = 1'b1;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r         <= S_IDLE;
			tick_r       <= 32'h0;
			out_freq     <= 16'h0;
			estop_active <= 1'b0;
			insp_run_r   <= 1'b0;
			brake_open   <= 1'b0;
			contactor    <= 1'b0;
			baseblock    <= 1'b1;
			dir_d_r      <= 1'b0;
			insp_d_r     <= 1'b0;
		end else begin
			st_r         <= st_nxt;
			tick_r       <= tick_nxt;
			out_freq     <= freq_nxt;
			estop_active <= estop_nxt;
			insp_run_r   <= insp_nxt;
			brake_open   <= brake_nxt;
			contactor    <= cont_nxt;
			baseblock    <= bb_nxt;
			dir_d_r      <= dir;
			insp_d_r     <= insp_cmd;
		end
	end
	// sel_speed is read live, must be stable before direction
endmodule : eisr_sequencer

// *** tb/eisr_ctrl_model.sv ***
// Purpose: lift controller contacts facing the sequencer
// Assumes: bench gives contact level, direction and speed
// Notes:   direction follows the selections by 8 cycles
`timescale 1ns/100ps
module eisr_ctrl_model (
	// clock
	input  wire logic        hclk,
	// bench requests
	input  wire logic        c_contact,
	input  wire logic [1:0]  c_dir,
	input  wire logic [15:0] c_speed,
	// contacts to the drive
	output logic [4:0]       mf_in,
	output logic             run_up,
	output logic             run_down,
	output logic [15:0]      sel_speed
);
	logic [3:0] dly_r = 4'h0;
	initial begin
		mf_in = 5'h00;
		run_up = 1'b0;
		run_down = 1'b0;
		sel_speed = 16'h0000;
	end
	always @(posedge hclk) begin
		mf_in     <= {5{c_contact}};
		sel_speed <= c_speed;
		dly_r     <= (c_dir == 2'h0) ? 4'h0 : dly_r + {3'h0, dly_r != 4'h8};
		run_up    <= c_dir[0] && dly_r == 4'h8;
		run_down  <= c_dir[1] && dly_r == 4'h8;
	end
endmodule : eisr_ctrl_model

// *** tb/eisr_monitor.sv ***
// Purpose: port checks for the stop and inspection sequencer
// Assumes: one clock domain, hresetn low clears everything
// Notes:   bound to every eisr_sequencer instance
`timescale 1ns/100ps
module eisr_monitor
	import eisr_pkg::*;
(
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// observed ports
	input wire logic        run_up,
	input wire logic [15:0] out_freq,
	input wire logic        baseblock,
	input wire logic        brake_open,
	input wire logic        contactor,
	input wire logic [15:0] carrier_hz,
	input wire logic        estop_active
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_BRAKE_CONT: assert property (brake_open |-> contactor)
		else $error("brake open with contactor off");
	AST_CUT_OUTS: assert property (baseblock |-> !brake_open && !contactor)
		else $error("output cut with brake or contactor on");
	AST_CONT_DROP: assert property ($fell(brake_open) |-> !contactor)
		else $error("contactor kept after brake drop");
	AST_START_OUTS: assert property ($fell(baseblock) |-> brake_open && contactor)
		else $error("start without brake and contactor");
	AST_CARRIER: assert property (carrier_hz == CARRIER_INSP || carrier_hz == CARRIER_NORM)
		else $error("carrier out of set");
	AST_CARRIER_IDLE: assert property (baseblock && $past(baseblock) |-> carrier_hz == CARRIER_NORM)
		else $error("reduced carrier while output is cut");
	AST_ESTOP_DEC: assert property (estop_active && !baseblock |=> out_freq <= $past(out_freq))
		else $error("frequency rose in emergency stop");
	AST_ESTOP_HOLD: assert property (estop_active && baseblock |=> baseblock)
		else $error("restart during emergency stop");
	AST_ESTOP_LATCH: assert property (estop_active && run_up && $past(run_up, 5) |=> estop_active)
		else $error("emergency latch cleared under run");

	COV_START: cover property ($fell(baseblock));
	COV_ESTOP: cover property ($rose(estop_active));
	COV_INSP: cover property (carrier_hz == CARRIER_INSP && brake_open);
endmodule : eisr_monitor

bind eisr_sequencer eisr_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .run_up(run_up),
	.out_freq(out_freq), .baseblock(baseblock), .brake_open(brake_open), .contactor(contactor),
	.carrier_hz(carrier_hz), .estop_active(estop_active));

// *** tb/eisr_sequencer_test.sv ***
// Purpose: self-checking bench for eisr_sequencer
// Assumes: contacts come from eisr_ctrl_model
// Notes:   short tick keeps every ramp within the 4000-cycle wait limit
`timescale 1ns/100ps
module eisr_sequencer_test
	import eisr_pkg::*;
;
	localparam int TK = 10;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout, hresp, baseblock, brake_open, contactor, estop_active;
	logic        run_up, run_down, c_contact = 1'b0;
	logic [31:0] hrdata, rd;
	logic [4:0]  mf_in;
	logic [1:0]  c_dir = 2'h0;
	logic [15:0] sel_speed, out_freq, carrier_hz, c_speed = 16'h0;
	logic [7:0]  ra [9] = '{ADDR_PRIO, ADDR_ESTOP_T, ADDR_INSP_SPD, ADDR_INSP_T, ADDR_UPPER,
		ADDR_LOWER, ADDR_MINF, ADDR_ACCEL_T, 8'h30};
	logic [15:0] rv [9] = '{16'(RST_PRIO), RST_ESTOP_T, RST_INSP_SPD, RST_INSP_T, RST_UPPER,
		RST_LOWER, RST_MINF, RST_ACCEL_T, 16'h0};
	logic [15:0] cs [4] = '{16'd1000, 16'd1001, 16'd3000, 16'd3001};
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	int          n;

	always #5 hclk = ~hclk;
	eisr_sequencer #(.TICK_CYCLES(TK)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mf_in(mf_in), .run_up(run_up), .run_down(run_down), .sel_speed(sel_speed),
		.out_freq(out_freq), .baseblock(baseblock), .brake_open(brake_open),
		.contactor(contactor), .carrier_hz(carrier_hz), .estop_active(estop_active));
	eisr_ctrl_model i_ctl (.hclk(hclk), .c_contact(c_contact), .c_dir(c_dir),
		.c_speed(c_speed), .mf_in(mf_in), .run_up(run_up), .run_down(run_down),
		.sel_speed(sel_speed));

	task end_sim();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : ahb
	// modes: 0 freq equals v, 1 idle, 2 latch equals v, 3 brake open
	task wt(input int m, input logic [15:0] v);
		n = 0;
		while (n < 4000 && !(m == 0 ? out_freq === v : m == 1 ? baseblock === 1'b1
			&& out_freq === 16'h0 : m == 2 ? estop_active === v[0] : brake_open === 1'b1)) begin
			@(posedge hclk);
			n++;
		end
		chk(32'(n < 4000), 32'h1);
	endtask : wt

	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(32'({hreadyout, hresp, baseblock, carrier_hz}), 32'({3'b101, CARRIER_NORM}));
		for (int i = 0; i < 9; i++) begin
			ahb(1'b0, ra[i], 32'h0);
			chk(rd, {16'h0, rv[i]});
		end
		ahb(1'b1, ADDR_PRIO, 32'h1);
		ahb(1'b1, ADDR_FUNC, 32'h54545454);
		c_contact <= 1'b1;
		c_dir <= 2'h1;
		wt(0, RST_INSP_SPD);
		chk(32'({brake_open, contactor, baseblock, carrier_hz}), 32'({3'b110, CARRIER_INSP}));
		c_contact <= 1'b0;
		wt(1, 16'h0);
		chk(32'(n < 9), 32'h1);
		c_dir <= 2'h0;
		repeat (20) @(posedge hclk);
		wt(1, 16'h0);
		ahb(1'b1, ADDR_INSP_T, 32'd10);
		c_contact <= 1'b1;
		c_dir <= 2'h2;
		wt(0, RST_INSP_SPD);
		c_dir <= 2'h0;
		repeat (3 * TK + 8) @(posedge hclk);
		chk(32'(out_freq < RST_INSP_SPD && brake_open), 32'h1);
		wt(1, 16'h0);
		chk(32'(n > TK), 32'h1);
		ahb(1'b1, ADDR_UPPER, 32'd3000);
		ahb(1'b1, ADDR_LOWER, 32'd1000);
		ahb(1'b1, ADDR_PRIO, 32'h0);
		c_speed <= 16'd2000;
		c_dir <= 2'h1;
		wt(3, 16'h0);
		repeat (2) @(posedge hclk);
		chk(32'(carrier_hz), 32'(CARRIER_NORM));
		c_dir <= 2'h0;
		wt(1, 16'h0);
		ahb(1'b1, ADDR_FUNC, 32'h0);
		for (int i = 0; i < 4; i++) begin
			c_speed <= cs[i];
			c_dir <= 2'h1;
			wt(3, 16'h0);
			repeat (2) @(posedge hclk);
			chk(32'(carrier_hz), 32'(i == 1 || i == 2 ? CARRIER_INSP : CARRIER_NORM));
			c_dir <= 2'h0;
			wt(1, 16'h0);
		end
		c_contact <= 1'b0;
		ahb(1'b1, ADDR_FUNC, 32'h0f0f0f0f);
		c_speed <= 16'd900;
		c_dir <= 2'h1;
		wt(0, 16'd900);
		ahb(1'b1, ADDR_ESTOP_T, 32'd5);
		c_contact <= 1'b1;
		wt(2, 16'h1);
		wt(1, 16'h0);
		// 900 down to minimum 50 in steps of 2500/150+1: 50 ticks
		chk(32'(n >= 50 * TK - 9 && n <= 50 * TK + 2), 32'h1);
		ahb(1'b0, ADDR_ESTOP_T, 32'h0);
		chk(rd, 32'(RST_ESTOP_T));
		c_contact <= 1'b0;
		repeat (20) @(posedge hclk);
		chk(32'({estop_active, baseblock}), 32'h3);
		c_dir <= 2'h0;
		wt(2, 16'h0);
		ahb(1'b1, ADDR_FUNC, 32'h11111111);
		c_contact <= 1'b1;
		wt(2, 16'h0);
		c_dir <= 2'h1;
		wt(3, 16'h0);
		c_contact <= 1'b0;
		wt(2, 16'h1);
		c_contact <= 1'b1;
		c_dir <= 2'h0;
		wt(1, 16'h0);
		wt(2, 16'h0);
		end_sim();
	end
endmodule : eisr_sequencer_test
